// [testbench/sgp_pins.sv]
`timescale 1ns/1ps
module sgp_pins
  import sgp_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire sgp_pkg::sgp_pad_t pad_in,
  input  wire logic [5:0]        ext_en_in,
  input  wire logic [5:0]        ext_val_in,
  output logic [5:0]             pin_out
);
  // Floating pins wander so a stale level is never mistaken for a read
  logic [5:0] float_q = 6'h2A;
  always_ff @(posedge clk_sys_in)
    float_q <= ~float_q;
  // External drive overrides the pad, as a load holding a driven pin would
  always_comb
    for (int i = 0; i < 6; i++)
      pin_out[i] = ext_en_in[i] ? ext_val_in[i] :
                   pad_in.out_en[i] ? pad_in.out_val[i] : pad_in.pullup_en[i] | float_q[i];
endmodule : sgp_pins

// [testbench/sgp_port_assertions.sv]
`timescale 1ns/1ps
module sgp_port_assertions
  import sgp_pkg::*;
(
  input wire logic              clk_sys_in,
  input wire logic              resetn_in,
  input wire sgp_pkg::sgp_req_t req_in,
  input wire logic [5:0]        pin_level_in,
  input wire logic [5:0]        alt_func_in,
  input wire logic              master_clear_input_enable_in,
  input wire logic              wake_reset_in,
  input wire logic              sleeping_in,
  input wire logic [7:0]        rdata_out,
  input wire logic              rvalid_out,
  input wire sgp_pkg::sgp_pad_t pad_out,
  input wire logic              wake_event_out,
  input wire logic [7:0]        cfg_out,
  input wire logic              timer_clk_ext_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  sequence s_read;
    req_in.op == SGP_OP_READ;
  endsequence
  sequence s_port_read;
    s_read ##0 req_in.addr == SGP_ADDR_PORT;
  endsequence
  a_pin3_input: assert property (!pad_out.out_en[SGP_MASTER_CLEAR_INPUT_PIN])
    else $error("pin 3 driven");
  a_tclk_forces_in: assert property (timer_clk_ext_out && $past(timer_clk_ext_out)
    |-> !pad_out.out_en[SGP_TCLK_PIN]) else $error("timer pin driven");
  a_drive_kills_pull: assert property ((pad_out.out_en & pad_out.pullup_en) == 6'h00)
    else $error("pull-up on a driven pin");
  a_pull_pin_set: assert property ((pad_out.pullup_en & ~SGP_WAKE_PINS) == 6'h00)
    else $error("pull-up outside pins 0 1 3");
  a_cfg_load: assert property (req_in.op == SGP_OP_LOAD_CFG
    |=> cfg_out == $past(req_in.wdata)) else $error("config not loaded");
  a_read_answer: assert property (s_read |=> rvalid_out)
    else $error("read not answered");
  a_port_top_zero: assert property (s_port_read |=> rdata_out[7:6] == 2'h0)
    else $error("upper port bits nonzero");
  a_alt_reads_zero: assert property (s_port_read
    |=> (rdata_out[5:0] & $past(alt_func_in)) == 6'h00) else $error("alternate pin read high");
  a_master_clear_input_pullup: assert property ($past(master_clear_input_enable_in) && $past(resetn_in)
    |-> pad_out.pullup_en[SGP_MASTER_CLEAR_INPUT_PIN]) else $error("master clear pull-up off");
  a_wake_asleep: assert property (wake_event_out |-> $past(sleeping_in))
    else $error("wake event while awake");
  a_reset_inputs: assert property ($rose(resetn_in) |-> pad_out.out_en == 6'h00)
    else $error("pin driven after reset");
endmodule : sgp_port_assertions

bind sgp_port sgp_port_assertions u_chk (
  .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .req_in(req_in),
  .pin_level_in(pin_level_in), .alt_func_in(alt_func_in), .master_clear_input_enable_in(master_clear_input_enable_in),
  .wake_reset_in(wake_reset_in), .sleeping_in(sleeping_in), .rdata_out(rdata_out),
  .rvalid_out(rvalid_out), .pad_out(pad_out), .wake_event_out(wake_event_out),
  .cfg_out(cfg_out), .timer_clk_ext_out(timer_clk_ext_out)
);

// [testbench/tb_six_bit_gpio_port.sv]
`timescale 1ns/1ps
module tb_six_bit_gpio_port;
  import sgp_pkg::*;
  logic       clk_sys_in, resetn_in, master_clear_input, wake_rst, rvalid, wake_ev, tclk, sleep;
  sgp_req_t   req;
  sgp_pad_t   pad;
  logic [5:0] pins, alt, ext_en, ext_val;
  logic [7:0] rdata, cfg;
  int         fail_count = 0;
  int         n_compared = 0;
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  sgp_port DUT (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .req_in(req),
    .pin_level_in(pins), .alt_func_in(alt), .master_clear_input_enable_in(master_clear_input), .wake_reset_in(wake_rst),
    .sleeping_in(sleep), .rdata_out(rdata), .rvalid_out(rvalid), .pad_out(pad),
    .wake_event_out(wake_ev), .cfg_out(cfg), .timer_clk_ext_out(tclk));
  sgp_pins u_pins (.clk_sys_in(clk_sys_in), .pad_in(pad), .ext_en_in(ext_en),
    .ext_val_in(ext_val), .pin_out(pins));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask : chk
  task automatic op(input sgp_op_t o, input logic [4:0] a, input logic [2:0] b,
                    input logic [7:0] w);
    @(posedge clk_sys_in);
    #1 req = '{op: o, addr: a, bit_sel: b, wdata: w};
    @(posedge clk_sys_in);
    #1 req.op = SGP_OP_NONE;
  endtask : op
  task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string what);
    // The answer stands for one cycle, right after the request edge
    op(SGP_OP_READ, a, 3'h0, 8'h00);
    chk({7'h00, rvalid}, 8'h01, "rvalid");
    chk(rdata, exp, what);
  endtask : rd
  // Pins reach the read path through a two-stage synchroniser
  task automatic settle();
    repeat (4) @(posedge clk_sys_in);
    #1;
  endtask : settle
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  initial
  begin
    #50000;
    fail_count++;
    end_sim();
  end
  initial
  begin
    {resetn_in, master_clear_input, sleep, alt, ext_en, ext_val} = '0;
    req = '0;
    wake_rst = 1'b1;
    repeat (8) @(posedge clk_sys_in);
    #1 resetn_in = 1'b1;
    chk({2'h0, pad.out_en}, 8'h00, "out_en");
    chk(cfg, 8'hFF, "cfg");
    rd(SGP_ADDR_STATUS, 8'h80, "status");
    wake_rst = 1'b0;
    resetn_in = 1'b0;
    #10 resetn_in = 1'b1;
    rd(SGP_ADDR_STATUS, 8'h00, "status");
    op(SGP_OP_WRITE, SGP_ADDR_PORT, 3'h0, 8'hD5);
    op(SGP_OP_LOAD_DIR, 5'h00, 3'h0, 8'h00);
    settle();
    chk({2'h0, pad.out_en}, 8'h33, "out_en");
    chk({2'h0, pad.out_val}, 8'h15, "out_val");
    op(SGP_OP_LOAD_CFG, 5'h00, 3'h0, 8'h00);
    settle();
    chk({2'h0, pad.out_en}, 8'h37, "out_en");
    chk({7'h00, tclk}, 8'h00, "tclk");
    chk({2'h0, pad.pullup_en}, 8'h08, "pullup");
    rd(SGP_ADDR_PORT, 8'h1D, "port");
    ext_en = 6'h01;
    settle();
    rd(SGP_ADDR_PORT, 8'h1C, "port");
    alt = 6'h10;
    settle();
    rd(SGP_ADDR_PORT, 8'h0C, "port");
    alt = 6'h00;
    // Pin 4 must be driven again before its level is read back
    settle();
    // Pin 0 held low while driven high shows why mixed bit ops lose latch state
    op(SGP_OP_BSET, SGP_ADDR_PORT, 3'h5, 8'h00);
    ext_en = 6'h00;
    settle();
    chk({2'h0, pad.out_val}, 8'h3C, "out_val");
    op(SGP_OP_BCLR, SGP_ADDR_PORT, 3'h2, 8'h00);
    settle();
    chk({2'h0, pad.out_val}, 8'h38, "out_val");
    op(SGP_OP_LOAD_DIR, 5'h00, 3'h0, 8'h3F);
    settle();
    chk({2'h0, pad.pullup_en}, 8'h0B, "pullup");
    chk({2'h0, pad.out_en}, 8'h00, "out_en");
    op(SGP_OP_LOAD_CFG, 5'h00, 3'h0, 8'h40);
    settle();
    chk({2'h0, pad.pullup_en}, 8'h00, "pullup");
    master_clear_input = 1'b1;
    settle();
    chk({2'h0, pad.pullup_en}, 8'h08, "pullup");
    // Hold pins 0 and 1 so only deliberate changes can wake
    ext_val = 6'h03;
    ext_en  = 6'h03;
    settle();
    sleep = 1'b1;
    settle();
    chk({7'h00, wake_ev}, 8'h00, "wake");
    ext_en = 6'h0B;
    settle();
    chk({7'h00, wake_ev}, 8'h00, "wake");
    ext_val = 6'h02;
    settle();
    chk({7'h00, wake_ev}, 8'h01, "wake");
    sleep  = 1'b0;
    ext_en = 6'h00;
    settle();
    chk({7'h00, wake_ev}, 8'h00, "wake");
    rd(5'h10, 8'h00, "unmapped");
    end_sim();
  end
endmodule : tb_six_bit_gpio_port

// [verilog/sgp_pkg.sv]
package sgp_pkg;

  localparam int          SGP_PINS          = 6;
  localparam int          SGP_DW            = 8;
  localparam logic [4:0]  SGP_ADDR_STATUS   = 5'h03;
  localparam logic [4:0]  SGP_ADDR_PORT     = 5'h06;
  localparam logic [7:0]  SGP_CFG_RESET     = 8'hFF;
  localparam logic [5:0]  SGP_DIR_RESET     = 6'h3F;
  localparam int          SGP_CFG_WAKE_BIT  = 7;
  localparam int          SGP_CFG_PULL_BIT  = 6;
  localparam int          SGP_CFG_TCS_BIT   = 5;
  localparam int          SGP_CFG_TSE_BIT   = 4;
  localparam int          SGP_CFG_PSA_BIT   = 3;
  localparam int          SGP_STAT_WAKE_BIT = 7;
  localparam int          SGP_TCLK_PIN      = 2;
  localparam int          SGP_MASTER_CLEAR_INPUT_PIN      = 3;
  localparam logic [5:0]  SGP_WAKE_PINS     = 6'h0B;
  localparam logic [5:0]  SGP_INPUT_ONLY    = 6'h08;

  typedef enum logic [2:0] {
    SGP_OP_NONE,
    SGP_OP_WRITE,
    SGP_OP_READ,
    SGP_OP_BSET,
    SGP_OP_BCLR,
    SGP_OP_LOAD_DIR,
    SGP_OP_LOAD_CFG
  } sgp_op_t;

  typedef struct packed {
    sgp_op_t     op;
    logic [4:0]  addr;
    logic [2:0]  bit_sel;
    logic [7:0]  wdata;
  } sgp_req_t;

  typedef struct packed {
    logic [5:0]  out_val;
    logic [5:0]  out_en;
    logic [5:0]  pullup_en;
  } sgp_pad_t;

endpackage : sgp_pkg

// [verilog/sgp_port.sv]
`timescale 1ns/1ps
// Operation
// - Output direction disables pull-up and wake-on-change on that pin
// - Timer external clock select forces pin 2 to input
// - Port read returns pin levels, not latches
// - Reset makes every pin a high-impedance input
// - Port register is 8 bits; upper two bits read zero
// - Pins in alternate function read as zero
// - Pins 0, 1, 3 offer weak pull-up and wake-on-change
// - Pull-up and wake enables act on pins 0, 1, 3 together
// - Pin 3 as master clear: pull-up always on, no wake; here the pull-up is off while reset is held
// - Direction-load instruction copies working register; write-only
// - Direction 1 tristates the driver; 0 drives the latch
// - Pin 3 input only; others individually programmable
// - Inputs sampled at read; output latches hold until rewritten
// - Bit set/clear reads pins, modifies a bit, writes all latches
// - Status top bit set on wake reset, cleared otherwise
// - Port write lands at cycle end; read samples at cycle start
// - Configuration loaded by instruction; reset sets all eight bits
module sgp_port
  import sgp_pkg::*;
(
  input  wire logic                  clk_sys_in,
  input  wire logic                  resetn_in,
  input  wire sgp_pkg::sgp_req_t     req_in,
  input  wire logic [5:0]            pin_level_in,
  input  wire logic [5:0]            alt_func_in,
  input  wire logic                  master_clear_input_enable_in,
  input  wire logic                  wake_reset_in,
  input  wire logic                  sleeping_in,
  output logic [7:0]                 rdata_out,
  output logic                       rvalid_out,
  output sgp_pkg::sgp_pad_t          pad_out,
  output logic                       wake_event_out,
  output logic [7:0]                 cfg_out,
  output logic                       timer_clk_ext_out
);

  import sgp_pkg::*;

  logic [5:0] pins_sync;
  logic [5:0] latch_q;
  logic [5:0] dir_q;
  logic [7:0] cfg_q;
  logic       wake_flag_q;
  logic       rst_seen_q;
  logic [5:0] wake_ref_q;
  logic [7:0] rdata_q;
  logic       rvalid_q;
  logic [5:0] port_view;
  logic [5:0] eff_dir;
  logic [5:0] wake_mask;
  logic [5:0] pull_mask;
  logic [5:0] rmw_val;
  logic       is_port;

  // Pins are asynchronous to the core clock
  sgp_sync #(
    .W (SGP_PINS)
  ) u_pin_sync (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .async_in   (pin_level_in),
    .sync_out   (pins_sync)
  );

  function automatic logic [5:0] bit_onehot(input logic [2:0] sel);
    logic [5:0] m;
    m = '0;
    if (sel < 3'h6)
    begin
      m[sel] = 1'b1;
    end
    return m;
  endfunction : bit_onehot

  assign is_port = (req_in.addr == SGP_ADDR_PORT);

  // Alternate-function pins read as zero
  assign port_view = pins_sync & ~alt_func_in;

  // Effective direction: pin 3 never drives, pin 2 yields to external timer clock
  always_comb
  begin
    eff_dir = dir_q | SGP_INPUT_ONLY;
    if (cfg_q[SGP_CFG_TCS_BIT])
    begin
      eff_dir[SGP_TCLK_PIN] = 1'b1;
    end
  end

  // Shared enables over pins 0, 1, 3; a pin set to output drops both on that pin only
  always_comb
  begin
    pull_mask = cfg_q[SGP_CFG_PULL_BIT] ? 6'h00 : SGP_WAKE_PINS;
    wake_mask = cfg_q[SGP_CFG_WAKE_BIT] ? 6'h00 : SGP_WAKE_PINS;
    pull_mask = pull_mask & eff_dir;
    wake_mask = wake_mask & eff_dir;
    if (master_clear_input_enable_in)
    begin
      pull_mask[SGP_MASTER_CLEAR_INPUT_PIN] = 1'b1;
      wake_mask[SGP_MASTER_CLEAR_INPUT_PIN] = 1'b0;
    end
  end

  // Read-modify-write takes pin levels, not latches, into every latch
  always_comb
  begin
    rmw_val = port_view;
    if (req_in.op == SGP_OP_BSET)
    begin
      rmw_val = port_view | bit_onehot(req_in.bit_sel);
    end
    else if (req_in.op == SGP_OP_BCLR)
    begin
      rmw_val = port_view & ~bit_onehot(req_in.bit_sel);
    end
  end

  // Latches only change on a write; reset leaves them as they were in silicon,
  // here cleared for determinism
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      latch_q <= '0;
    end
    else if (is_port && req_in.op == SGP_OP_WRITE)
    begin
      latch_q <= req_in.wdata[5:0];
    end
    else if (is_port && (req_in.op == SGP_OP_BSET || req_in.op == SGP_OP_BCLR))
    begin
      latch_q <= rmw_val;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      dir_q <= SGP_DIR_RESET;
    end
    else if (req_in.op == SGP_OP_LOAD_DIR)
    begin
      dir_q <= req_in.wdata[5:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cfg_q <= SGP_CFG_RESET;
    end
    else if (req_in.op == SGP_OP_LOAD_CFG)
    begin
      cfg_q <= req_in.wdata;
    end
  end

  // Reset cause is captured on the first clock after release, not by the reset
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rst_seen_q  <= 1'b0;
      wake_flag_q <= 1'b0;
    end
    else if (!rst_seen_q)
    begin
      rst_seen_q  <= 1'b1;
      wake_flag_q <= wake_reset_in;
    end
  end

  // Reference snapshot for change detection, refreshed while awake
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wake_ref_q <= '0;
    end
    else if (!sleeping_in)
    begin
      wake_ref_q <= pins_sync;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wake_event_out <= 1'b0;
    end
    else
    begin
      wake_event_out <= sleeping_in && |((pins_sync ^ wake_ref_q) & wake_mask);
    end
  end

  // Read data is the pin image at the start of the instruction cycle
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= (req_in.op == SGP_OP_READ);
      if (req_in.op == SGP_OP_READ && is_port)
      begin
        rdata_q <= {2'b00, port_view};
      end
      else if (req_in.op == SGP_OP_READ && req_in.addr == SGP_ADDR_STATUS)
      begin
        rdata_q <= {wake_flag_q, 7'h00};
      end
      else if (req_in.op == SGP_OP_READ)
      begin
        rdata_q <= '0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pad_out <= '{out_val: 6'h00, out_en: 6'h00, pullup_en: 6'h00};
    end
    else
    begin
      pad_out.out_val   <= latch_q;
      pad_out.out_en    <= ~eff_dir & ~alt_func_in;
      pad_out.pullup_en <= pull_mask;
    end
  end

  assign rdata_out         = rdata_q;
  assign rvalid_out        = rvalid_q;
  assign cfg_out           = cfg_q;
  assign timer_clk_ext_out = cfg_q[SGP_CFG_TCS_BIT];

endmodule : sgp_port

// [verilog/sgp_sync.sv]
`timescale 1ns/1ps
module sgp_sync #(
  parameter int W = 6
) (
  input  wire logic         clk_sys_in,
  input  wire logic         resetn_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : sgp_sync
